/* sim/vcsw_analog.sv */
`timescale 1ns/1ps
module vcsw_analog (
  input  wire logic cc1_switch_en,
  input  wire logic cc2_switch_en,
  input  wire logic alert_n_oe,
  input  wire logic supply_on,
  input  wire logic rev_on,
  input  wire logic load_high,
  input  wire logic load_short,
  input  wire logic hot,
  output logic      cable_supply_input_ok,
  output logic      rev_voltage_det,
  output logic      overcurrent_det,
  output logic      short_det,
  output logic      overtemp_det,
  output logic      temp_recovered,
  output logic      alert_n_i
);
  logic on;
  // Load current flows only through a closed switch
  assign on = cc1_switch_en | cc2_switch_en;
  assign overcurrent_det = load_high & on;
  assign short_det = load_short & on;
  // Cable voltage and die heat do not depend on the switch
  assign cable_supply_input_ok = supply_on;
  assign rev_voltage_det = rev_on;
  assign overtemp_det = hot;
  assign temp_recovered = ~hot;
  // External pull-up on the alert wire
  assign alert_n_i = alert_n_oe ? 1'b0 : 1'b1;
endmodule

/* sim/vcsw_ctrl_monitor.sv */
`timescale 1ns/1ps
module vcsw_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       cable_supply_input_ok,
  input wire logic       rev_voltage_det,
  input wire logic       overcurrent_det,
  input wire logic       short_det,
  input wire logic       overtemp_det,
  input wire logic       temp_recovered,
  input wire logic       cc1_switch_en,
  input wire logic       cc2_switch_en,
  input wire logic       current_limit_en,
  input wire logic [1:0] overcurrent_limit_sel,
  input wire logic       alert_n_i,
  input wire logic       alert_n_o,
  input wire logic       alert_n_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic on;
  // Switch closed on either side
  assign on = cc1_switch_en | cc2_switch_en;

  a_cc_one_side: assert property (!(cc1_switch_en && cc2_switch_en))
    else $error("both cc switches on");
  a_supply_gate: assert property (!cable_supply_input_ok [*8] |-> !on)
    else $error("switch on without supply");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_alert_drain: assert property (alert_n_o == 1'b0)
    else $error("alert output not open drain");
  a_alert_sticky: assert property (alert_n_oe && !reg_wr && !$past(reg_wr) |=> alert_n_oe)
    else $error("alert dropped without host write");
  a_limit_follow: assert property (overcurrent_det [*6] ##0 on [*3] |-> current_limit_en)
    else $error("overcurrent without limiting");
  a_short_off: assert property ($rose(short_det) |-> ##[1:6] !on)
    else $error("short left switch on");
  a_hot_off: assert property (overtemp_det [*8] |-> !on)
    else $error("overtemperature left switch on");
  a_sel_hold: assert property (!$past(reg_wr) |-> $stable(overcurrent_limit_sel))
    else $error("limit select changed without write");
endmodule

bind vcsw_ctrl vcsw_monitor u_mon (
  .clk                   (clk),
  .sys_rst               (sys_rst),
  .reg_addr              (reg_addr),
  .reg_wdata             (reg_wdata),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .cable_supply_input_ok (cable_supply_input_ok),
  .rev_voltage_det       (rev_voltage_det),
  .overcurrent_det       (overcurrent_det),
  .short_det             (short_det),
  .overtemp_det          (overtemp_det),
  .temp_recovered        (temp_recovered),
  .cc1_switch_en         (cc1_switch_en),
  .cc2_switch_en         (cc2_switch_en),
  .current_limit_en      (current_limit_en),
  .overcurrent_limit_sel (overcurrent_limit_sel),
  .alert_n_i             (alert_n_i),
  .alert_n_o             (alert_n_o),
  .alert_n_oe            (alert_n_oe)
);

/* sim/vcsw_ctrl_tb.sv */
`timescale 1ns/1ps
module vcsw_ctrl_tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       cable_supply_input_ok, rev_voltage_det, overcurrent_det, short_det;
  logic       overtemp_det, temp_recovered, alert_n_i, alert_n_o, alert_n_oe;
  logic       cc1_switch_en, cc2_switch_en, current_limit_en;
  logic [1:0] overcurrent_limit_sel;
  logic       supply_on = 1'b1;
  logic       rev_on = 1'b0;
  logic       load_high = 1'b0;
  logic       load_short = 1'b0;
  logic       hot = 1'b0;
  logic       rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int         n_errors = 0;
  int         cmp_count = 0;

  vcsw_ctrl dut (
    .clk                   (clk),
    .sys_rst               (sys_rst),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_rdata             (reg_rdata),
    .cable_supply_input_ok (cable_supply_input_ok),
    .rev_voltage_det       (rev_voltage_det),
    .overcurrent_det       (overcurrent_det),
    .short_det             (short_det),
    .overtemp_det          (overtemp_det),
    .temp_recovered        (temp_recovered),
    .cc1_switch_en         (cc1_switch_en),
    .cc2_switch_en         (cc2_switch_en),
    .current_limit_en      (current_limit_en),
    .overcurrent_limit_sel (overcurrent_limit_sel),
    .alert_n_i             (alert_n_i),
    .alert_n_o             (alert_n_o),
    .alert_n_oe            (alert_n_oe)
  );

  vcsw_analog u_far (
    .cc1_switch_en         (cc1_switch_en),
    .cc2_switch_en         (cc2_switch_en),
    .alert_n_oe            (alert_n_oe),
    .supply_on             (supply_on),
    .rev_on                (rev_on),
    .load_high             (load_high),
    .load_short            (load_short),
    .hot                   (hot),
    .cable_supply_input_ok (cable_supply_input_ok),
    .rev_voltage_det       (rev_voltage_det),
    .overcurrent_det       (overcurrent_det),
    .short_det             (short_det),
    .overtemp_det          (overtemp_det),
    .temp_recovered        (temp_recovered),
    .alert_n_i             (alert_n_i)
  );

  // Free running clock
  initial forever #4 clk = ~clk;

  task automatic fail(input string m);
    n_errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] e);
    cmp_count++;
    if (reg_rdata !== e) fail("read data");
  endtask

  task automatic chk_pin(input logic [3:0] e, input logic [1:0] s);
    cmp_count++;
    if ({cc1_switch_en, cc2_switch_en, current_limit_en, alert_n_oe} !== e) fail("pins");
    if (overcurrent_limit_sel !== s) fail("limit select");
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Bounded wait for the switch to reach a level
  task automatic wait_on(input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      if ((cc1_switch_en | cc2_switch_en) === v) return;
    end
    fail("switch wait timeout");
    end_of_test();
  endtask

  // Read data checker, one cycle after each strobe
  always @(posedge clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) fail("unexpected read data");
      else chk_rd(exp_q.pop_front());
    end
    rd_d <= reg_rd;
  end

  // Main sequence
  initial begin
    logic [7:0] r;
    void'($urandom(32'h800EDA5F));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(vcsw_pkg::VCSW_REG_CTRL, vcsw_pkg::VCSW_CTRL_RST);
    rd(vcsw_pkg::VCSW_REG_DEGLITCH, vcsw_pkg::VCSW_DEGLITCH_RST);
    rd(vcsw_pkg::VCSW_REG_REATTEMPT, {4'h0, vcsw_pkg::VCSW_REATTEMPT_RST});
    rd(vcsw_pkg::VCSW_REG_RV_DELAY, vcsw_pkg::VCSW_RV_DELAY_RST);
    rd(vcsw_pkg::VCSW_REG_OT_DELAY, vcsw_pkg::VCSW_OT_DELAY_RST);
    rd(vcsw_pkg::VCSW_REG_MASK, {4'h0, vcsw_pkg::VCSW_MASK_RST});
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    chk_pin(4'h0, 2'h0);
    r = 8'($urandom);
    wr(vcsw_pkg::VCSW_REG_OT_DELAY, r);
    rd(vcsw_pkg::VCSW_REG_OT_DELAY, r);
    wr(vcsw_pkg::VCSW_REG_DEGLITCH, 8'h02);
    wr(vcsw_pkg::VCSW_REG_REATTEMPT, 8'h02);
    wr(vcsw_pkg::VCSW_REG_RV_DELAY, 8'h02);
    wr(vcsw_pkg::VCSW_REG_OT_DELAY, 8'h02);
    // Orientation selects the CC pin, supply gates the switch
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h05);
    wait_on(1'b1, 20);
    chk_pin(4'h4, 2'h0);
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h04);
    wait_on(1'b0, 20);
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h07);
    wait_on(1'b1, 20);
    chk_pin(4'h8, 2'h0);
    supply_on <= 1'b0;
    wait_on(1'b0, 20);
    repeat (30) @(posedge clk);
    chk_pin(4'h0, 2'h0);
    supply_on <= 1'b1;
    wait_on(1'b1, 20);
    // Four limit levels, then overcurrent
    for (int i = 0; i < 4; i++) begin
      wr(vcsw_pkg::VCSW_REG_CTRL, {2'b00, 2'(i), 4'h7});
      @(posedge clk);
      chk_pin(4'h8, 2'(i));
    end
    load_high <= 1'b1;
    repeat (10) @(posedge clk);
    chk_pin(4'hB, 2'h3);
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h08);
    rd(vcsw_pkg::VCSW_REG_INT, 8'h08);
    load_high <= 1'b0;
    repeat (10) @(posedge clk);
    chk_pin(4'h9, 2'h3);
    wr(vcsw_pkg::VCSW_REG_FAULT, 8'h08);
    wr(vcsw_pkg::VCSW_REG_INT, 8'h08);
    repeat (3) @(posedge clk);
    chk_pin(4'h8, 2'h3);
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h00);
    // Masked short to ground
    wr(vcsw_pkg::VCSW_REG_MASK, 8'h04);
    load_short <= 1'b1;
    wait_on(1'b0, 20);
    load_short <= 1'b0;
    wait_on(1'b1, 400);
    // Forced limit after the short also flags overcurrent, which is unmasked
    chk_pin(4'hB, 2'h3);
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h0C);
    rd(vcsw_pkg::VCSW_REG_INT, 8'h0C);
    wr(vcsw_pkg::VCSW_REG_INT, 8'h08);
    repeat (3) @(posedge clk);
    chk_pin(4'hA, 2'h3);
    wr(vcsw_pkg::VCSW_REG_FAULT, 8'h0C);
    wr(vcsw_pkg::VCSW_REG_INT, 8'h04);
    wr(vcsw_pkg::VCSW_REG_MASK, 8'h00);
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h04);
    wait_on(1'b0, 20);
    // Reverse voltage: deglitch, reassert once, lock on the second trip
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h07);
    wait_on(1'b1, 20);
    rev_on <= 1'b1;
    repeat (100) @(posedge clk);
    chk_pin(4'h8, 2'h0);
    wait_on(1'b0, 200);
    repeat (100) @(posedge clk);
    chk_pin(4'h0, 2'h0);
    rd(vcsw_pkg::VCSW_REG_STATE, 8'h14);
    wait_on(1'b1, 200);
    wait_on(1'b0, 400);
    repeat (600) @(posedge clk);
    chk_pin(4'h1, 2'h0);
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h01);
    rd(vcsw_pkg::VCSW_REG_STATE, 8'h2C);
    rd(vcsw_pkg::VCSW_REG_RETRY, 8'h01);
    rev_on <= 1'b0;
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h04);
    wr(vcsw_pkg::VCSW_REG_FAULT, 8'h01);
    wr(vcsw_pkg::VCSW_REG_INT, 8'h01);
    repeat (3) @(posedge clk);
    chk_pin(4'h0, 2'h0);
    // Guard off ignores reverse voltage
    rev_on <= 1'b1;
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h01);
    wait_on(1'b1, 20);
    repeat (400) @(posedge clk);
    chk_pin(4'h4, 2'h0);
    rev_on <= 1'b0;
    // Overtemperature trip and recovery, then host disable mid-recovery
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h05);
    hot <= 1'b1;
    wait_on(1'b0, 20);
    repeat (4) @(posedge clk);
    chk_pin(4'h1, 2'h0);
    rd(vcsw_pkg::VCSW_REG_FAULT, 8'h02);
    hot <= 1'b0;
    repeat (100) @(posedge clk);
    chk_pin(4'h1, 2'h0);
    wait_on(1'b1, 200);
    hot <= 1'b1;
    wait_on(1'b0, 20);
    wr(vcsw_pkg::VCSW_REG_CTRL, 8'h04);
    hot <= 1'b0;
    repeat (400) @(posedge clk);
    chk_pin(4'h1, 2'h0);
    wr(vcsw_pkg::VCSW_REG_INT, 8'h02);
    wr(vcsw_pkg::VCSW_REG_FAULT, 8'h02);
    repeat (3) @(posedge clk);
    chk_pin(4'h0, 2'h0);
    if (exp_q.size() != 0) fail("reads left unanswered");
    end_of_test();
  end
endmodule

/* src/vcsw_ctrl.sv */
`timescale 1ns/1ps
module vcsw_ctrl (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       cable_supply_input_ok,
  input  wire logic       rev_voltage_det,
  input  wire logic       overcurrent_det,
  input  wire logic       short_det,
  input  wire logic       overtemp_det,
  input  wire logic       temp_recovered,
  output logic            cc1_switch_en,
  output logic            cc2_switch_en,
  output logic            current_limit_en,
  output logic      [1:0] overcurrent_limit_sel,
  input  wire logic       alert_n_i,
  output logic            alert_n_o,
  output logic            alert_n_oe
);
  // Synchronised views of the analog indications
  logic [vcsw_pkg::VCSW_NSYNC-1:0] pins;
  logic [vcsw_pkg::VCSW_NSYNC-1:0] lvl;
  logic supply_ok;
  logic rv_det;
  logic oc_det;
  logic sc_det;
  logic ot_det;
  logic ot_rec;
  logic alert_pin; // High while the alert wire is low

  assign pins = {~alert_n_i, temp_recovered, overtemp_det, short_det,
                 overcurrent_det, rev_voltage_det, cable_supply_input_ok};

  vcsw_pin_sync #(
    .W (vcsw_pkg::VCSW_NSYNC)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin_i   (pins),
    .level_o (lvl)
  );

  assign supply_ok = lvl[0];
  assign rv_det    = lvl[1];
  assign oc_det    = lvl[2];
  assign sc_det    = lvl[3];
  assign ot_det    = lvl[4];
  assign ot_rec    = lvl[5];
  assign alert_pin = lvl[6];

  // Host registers
  logic [7:0] ctrl_ff;
  logic [7:0] deglitch_ff;
  logic [3:0] reattempt_ff;
  logic [7:0] rv_delay_ff;
  logic [7:0] ot_delay_ff;
  logic [vcsw_pkg::VCSW_NFAULT-1:0] mask_ff;
  logic [vcsw_pkg::VCSW_NFAULT-1:0] fault_ff;
  logic [vcsw_pkg::VCSW_NFAULT-1:0] int_ff;
  logic [vcsw_pkg::VCSW_NFAULT-1:0] nxt_fault;
  logic [vcsw_pkg::VCSW_NFAULT-1:0] nxt_int;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Core state
  vcsw_pkg::vcsw_state_t state_ff;
  vcsw_pkg::vcsw_state_t nxt_state;
  logic [6:0] tick_cnt_ff;
  logic       tick;
  logic [7:0] timer_ff;
  logic [7:0] nxt_timer;
  logic [7:0] glitch_cnt_ff;
  logic [7:0] nxt_glitch_cnt;
  logic [3:0] retry_ff;
  logic [3:0] nxt_retry;
  logic       sc_limit_ff;
  logic       nxt_sc_limit;
  logic       limit_ff;

  // Address decode
  logic wr_ctrl;
  logic wr_deglitch;
  logic wr_reattempt;
  logic wr_rv_delay;
  logic wr_ot_delay;
  logic wr_mask;
  logic wr_fault;
  logic wr_int;

  assign wr_ctrl      = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_CTRL);
  assign wr_deglitch  = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_DEGLITCH);
  assign wr_reattempt = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_REATTEMPT);
  assign wr_rv_delay  = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_RV_DELAY);
  assign wr_ot_delay  = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_OT_DELAY);
  assign wr_mask      = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_MASK);
  assign wr_fault     = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_FAULT);
  assign wr_int       = reg_wr && (reg_addr == vcsw_pkg::VCSW_REG_INT);

  // Control fields
  logic       host_en;
  logic       orient;
  logic       guard_en;
  logic       allow_on;

  assign host_en  = ctrl_ff[vcsw_pkg::VCSW_CTRL_EN];
  assign orient   = ctrl_ff[vcsw_pkg::VCSW_CTRL_ORIENT];
  assign guard_en = ctrl_ff[vcsw_pkg::VCSW_CTRL_GUARD];
  assign allow_on = host_en && supply_ok;

  // Settings registers written by the host
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff      <= vcsw_pkg::VCSW_CTRL_RST;
      deglitch_ff  <= vcsw_pkg::VCSW_DEGLITCH_RST;
      reattempt_ff <= vcsw_pkg::VCSW_REATTEMPT_RST;
      rv_delay_ff  <= vcsw_pkg::VCSW_RV_DELAY_RST;
      ot_delay_ff  <= vcsw_pkg::VCSW_OT_DELAY_RST;
      mask_ff      <= vcsw_pkg::VCSW_MASK_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= reg_wdata;
      if (wr_deglitch) deglitch_ff <= reg_wdata;
      if (wr_reattempt) reattempt_ff <= reg_wdata[3:0];
      if (wr_rv_delay) rv_delay_ff <= reg_wdata;
      if (wr_ot_delay) ot_delay_ff <= reg_wdata;
      if (wr_mask) mask_ff <= reg_wdata[vcsw_pkg::VCSW_NFAULT-1:0];
    end
  end

  // One microsecond tick for all timers
  assign tick = (tick_cnt_ff == 7'(vcsw_pkg::VCSW_TICK_CYC - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_cnt_ff <= 7'h00;
    end else begin
      tick_cnt_ff <= tick ? 7'h00 : tick_cnt_ff + 7'h01;
    end
  end

  // Reverse voltage deglitch
  logic rv_watch;
  logic rv_trip;
  logic retry_done;

  assign rv_watch   = (state_ff == vcsw_pkg::VCSW_ON) && guard_en && rv_det;
  assign rv_trip    = rv_watch && (glitch_cnt_ff >= deglitch_ff);
  assign retry_done = (retry_ff + 4'h1) >= reattempt_ff;

  always_comb begin
    nxt_glitch_cnt = 8'h00;
    if (rv_watch && !rv_trip) begin
      nxt_glitch_cnt = (tick && glitch_cnt_ff != 8'hFF) ? glitch_cnt_ff + 8'h01
                                                       : glitch_cnt_ff;
    end
  end

  // Timer done flag shared by recovery states
  logic timer_zero;
  assign timer_zero = (timer_ff == 8'h00);

  // Switch sequencing
  always_comb begin
    nxt_state    = state_ff;
    nxt_timer    = timer_ff;
    nxt_retry    = retry_ff;
    nxt_sc_limit = sc_limit_ff;
    if (tick && !timer_zero) begin
      nxt_timer = timer_ff - 8'h01;
    end
    if (!allow_on) begin
      nxt_state    = vcsw_pkg::VCSW_OFF;
      nxt_retry    = 4'h0;
      nxt_sc_limit = 1'b0;
    end else begin
      unique case (state_ff)
        vcsw_pkg::VCSW_OFF: begin
          nxt_state = vcsw_pkg::VCSW_ON;
        end
        vcsw_pkg::VCSW_ON: begin
          if (sc_det) begin
            nxt_state = vcsw_pkg::VCSW_SC_OFF;
            nxt_timer = 8'(vcsw_pkg::VCSW_SHORT_TICKS);
          end else if (ot_det) begin
            nxt_state = vcsw_pkg::VCSW_OT_WAIT;
            nxt_timer = ot_delay_ff;
          end else if (rv_trip) begin
            if (retry_done) begin
              nxt_state = vcsw_pkg::VCSW_LOCKED;
            end else begin
              nxt_state = vcsw_pkg::VCSW_RV_WAIT;
              nxt_timer = rv_delay_ff;
              nxt_retry = retry_ff + 4'h1;
            end
          end
        end
        vcsw_pkg::VCSW_RV_WAIT: begin
          if (timer_zero) begin
            nxt_state = vcsw_pkg::VCSW_ON;
          end
        end
        vcsw_pkg::VCSW_OT_WAIT: begin
          if (!ot_rec || ot_det) begin
            nxt_timer = ot_delay_ff;
          end else if (timer_zero) begin
            nxt_state = vcsw_pkg::VCSW_ON;
          end
        end
        vcsw_pkg::VCSW_SC_OFF: begin
          if (timer_zero) begin
            nxt_state    = vcsw_pkg::VCSW_ON;
            nxt_sc_limit = 1'b1;
          end
        end
        vcsw_pkg::VCSW_LOCKED: begin
          nxt_state = vcsw_pkg::VCSW_LOCKED;
        end
        default: begin
          nxt_state = vcsw_pkg::VCSW_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff      <= vcsw_pkg::VCSW_OFF;
      timer_ff      <= 8'h00;
      retry_ff      <= 4'h0;
      sc_limit_ff   <= 1'b0;
      glitch_cnt_ff <= 8'h00;
    end else begin
      state_ff      <= nxt_state;
      timer_ff      <= nxt_timer;
      retry_ff      <= nxt_retry;
      sc_limit_ff   <= nxt_sc_limit;
      glitch_cnt_ff <= nxt_glitch_cnt;
    end
  end

  // Switch path drive
  logic sw_on;
  logic nxt_limit;

  assign sw_on     = (state_ff == vcsw_pkg::VCSW_ON);
  assign nxt_limit = (nxt_state == vcsw_pkg::VCSW_ON) && (oc_det || nxt_sc_limit);

  logic cc1_ff;
  logic cc2_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cc1_ff   <= 1'b0;
      cc2_ff   <= 1'b0;
      limit_ff <= 1'b0;
    end else begin
      cc1_ff   <= (nxt_state == vcsw_pkg::VCSW_ON) && orient;
      cc2_ff   <= (nxt_state == vcsw_pkg::VCSW_ON) && !orient;
      limit_ff <= nxt_limit;
    end
  end

  assign cc1_switch_en         = cc1_ff;
  assign cc2_switch_en         = cc2_ff;
  assign current_limit_en      = limit_ff;
  assign overcurrent_limit_sel = ctrl_ff[vcsw_pkg::VCSW_CTRL_LIM_LO +: 2];

  // Fault events
  logic [vcsw_pkg::VCSW_NFAULT-1:0] ev;

  assign ev[vcsw_pkg::VCSW_F_REV]   = sw_on && !sc_det && !ot_det && rv_trip && retry_done;
  assign ev[vcsw_pkg::VCSW_F_OTP]   = sw_on && !sc_det && ot_det;
  assign ev[vcsw_pkg::VCSW_F_SHORT] = sw_on && sc_det;
  assign ev[vcsw_pkg::VCSW_F_OVC]   = nxt_limit && !limit_ff;

  // Sticky status, write one to clear, a new event wins over its clear
  always_comb begin
    nxt_fault = fault_ff;
    nxt_int   = int_ff;
    if (wr_fault) nxt_fault = fault_ff & ~reg_wdata[vcsw_pkg::VCSW_NFAULT-1:0];
    if (wr_int) nxt_int = int_ff & ~reg_wdata[vcsw_pkg::VCSW_NFAULT-1:0];
    nxt_fault = nxt_fault | ev;
    nxt_int   = nxt_int | ev;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_ff <= '0;
      int_ff   <= '0;
    end else begin
      fault_ff <= nxt_fault;
      int_ff   <= nxt_int;
    end
  end

  // Level alert while any unmasked interrupt is pending
  logic alert_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_ff <= 1'b0;
    end else begin
      alert_ff <= |(nxt_int & ~mask_ff);
    end
  end

  assign alert_n_o  = 1'b0;
  assign alert_n_oe = alert_ff;

  // Readback
  logic [7:0] state_word;

  assign state_word = {2'b00, alert_pin,
                       (state_ff == vcsw_pkg::VCSW_RV_WAIT) ||
                       (state_ff == vcsw_pkg::VCSW_OT_WAIT) ||
                       (state_ff == vcsw_pkg::VCSW_SC_OFF),
                       (state_ff == vcsw_pkg::VCSW_LOCKED),
                       supply_ok, limit_ff, sw_on};

  always_comb begin
    nxt_rdata = 8'h00;
    unique case (reg_addr)
      vcsw_pkg::VCSW_REG_CTRL:      nxt_rdata = ctrl_ff;
      vcsw_pkg::VCSW_REG_DEGLITCH:  nxt_rdata = deglitch_ff;
      vcsw_pkg::VCSW_REG_REATTEMPT: nxt_rdata = {4'h0, reattempt_ff};
      vcsw_pkg::VCSW_REG_RV_DELAY:  nxt_rdata = rv_delay_ff;
      vcsw_pkg::VCSW_REG_OT_DELAY:  nxt_rdata = ot_delay_ff;
      vcsw_pkg::VCSW_REG_MASK:      nxt_rdata = {4'h0, mask_ff};
      vcsw_pkg::VCSW_REG_FAULT:     nxt_rdata = {4'h0, fault_ff};
      vcsw_pkg::VCSW_REG_INT:       nxt_rdata = {4'h0, int_ff};
      vcsw_pkg::VCSW_REG_STATE:     nxt_rdata = state_word;
      vcsw_pkg::VCSW_REG_RETRY:     nxt_rdata = {4'h0, retry_ff};
      default:                      nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

/* src/vcsw_pin_sync.sv */
`timescale 1ns/1ps
module vcsw_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] level_ff;

  // Three-stage chain per bit, level changes once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        s1_ff[i]    <= 1'b0;
        s2_ff[i]    <= 1'b0;
        s3_ff[i]    <= 1'b0;
        level_ff[i] <= 1'b0;
      end else begin
        s1_ff[i] <= pin_i[i];
        s2_ff[i] <= s1_ff[i];
        s3_ff[i] <= s2_ff[i];
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign level_o = level_ff;
endmodule

/* src/vcsw_pkg.sv */
package vcsw_pkg;
  // Register offsets
  localparam logic [3:0] VCSW_REG_CTRL      = 4'h0;
  localparam logic [3:0] VCSW_REG_DEGLITCH  = 4'h1;
  localparam logic [3:0] VCSW_REG_REATTEMPT = 4'h2;
  localparam logic [3:0] VCSW_REG_RV_DELAY  = 4'h3;
  localparam logic [3:0] VCSW_REG_OT_DELAY  = 4'h4;
  localparam logic [3:0] VCSW_REG_MASK      = 4'h5;
  localparam logic [3:0] VCSW_REG_FAULT     = 4'h6;
  localparam logic [3:0] VCSW_REG_INT       = 4'h7;
  localparam logic [3:0] VCSW_REG_STATE     = 4'h8;
  localparam logic [3:0] VCSW_REG_RETRY     = 4'h9;

  // Control register fields
  localparam int VCSW_CTRL_EN      = 0;
  localparam int VCSW_CTRL_ORIENT  = 1;
  localparam int VCSW_CTRL_GUARD   = 2;
  localparam int VCSW_CTRL_LIM_LO  = 4;
  localparam int VCSW_CTRL_LIM_HI  = 5;

  // Fault, interrupt and mask fields
  localparam int VCSW_F_REV   = 0;
  localparam int VCSW_F_OTP   = 1;
  localparam int VCSW_F_SHORT = 2;
  localparam int VCSW_F_OVC   = 3;
  localparam int VCSW_NFAULT  = 4;

  // State register fields
  localparam int VCSW_S_ON      = 0;
  localparam int VCSW_S_LIMIT   = 1;
  localparam int VCSW_S_SUPPLY  = 2;
  localparam int VCSW_S_LOCKED  = 3;
  localparam int VCSW_S_RECOVER = 4;
  localparam int VCSW_S_ALERT   = 5;

  // Reset values
  localparam logic [7:0] VCSW_CTRL_RST      = 8'h04;
  localparam logic [7:0] VCSW_DEGLITCH_RST  = 8'h0A;
  localparam logic [3:0] VCSW_REATTEMPT_RST = 4'h3;
  localparam logic [7:0] VCSW_RV_DELAY_RST  = 8'h64;
  localparam logic [7:0] VCSW_OT_DELAY_RST  = 8'hC8;
  localparam logic [3:0] VCSW_MASK_RST      = 4'h0;

  // Timing: the timers count ticks of one microsecond
  localparam int VCSW_CLK_NS       = 8;
  localparam int VCSW_TICK_NS      = 1000;
  localparam int VCSW_TICK_CYC     = (VCSW_TICK_NS + VCSW_CLK_NS - 1) / VCSW_CLK_NS;
  localparam int VCSW_SHORT_OFF_NS = 2000;
  localparam int VCSW_SHORT_TICKS  = (VCSW_SHORT_OFF_NS + VCSW_TICK_NS - 1) / VCSW_TICK_NS;

  // Number of synchronised inputs
  localparam int VCSW_NSYNC = 7;

  typedef enum logic [2:0] {
    VCSW_OFF,
    VCSW_ON,
    VCSW_RV_WAIT,
    VCSW_OT_WAIT,
    VCSW_SC_OFF,
    VCSW_LOCKED
  } vcsw_state_t;
endpackage
